// ---- common/pmbus_guard_pkg.sv ----
// Purpose: Shared constants for the write guard and settings store block
// Assumes: Core clock at 100 MHz
// Notes:   Codes are byte-wide command codes seen on the target port
package pmbus_guard_pkg;
  // Command codes handled here
  localparam logic [7:0] CODE_OPERATION   = 8'h01;
  localparam logic [7:0] CODE_ON_OFF      = 8'h02;
  localparam logic [7:0] CODE_WRITE_GUARD = 8'h10;
  localparam logic [7:0] CODE_STORE_ALL   = 8'h11;
  localparam logic [7:0] CODE_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CODE_FEATURE     = 8'h19;
  localparam logic [7:0] CODE_ALERT_MASK  = 8'h1B;
  localparam logic [7:0] CODE_VOUT        = 8'h21;
  // Status register codes accepted as mask targets
  localparam logic [7:0] ST_WORD  = 8'h79;
  localparam logic [7:0] ST_VOUT  = 8'h7A;
  localparam logic [7:0] ST_IOUT  = 8'h7B;
  localparam logic [7:0] ST_INPUT = 8'h7C;
  localparam logic [7:0] ST_TEMP  = 8'h7D;
  localparam logic [7:0] ST_CML   = 8'h7E;
  localparam logic [7:0] ST_MFR   = 8'h80;
  // Guard level field and its three valid settings
  localparam logic [7:0] GUARD_FIELD     = 8'hE0;
  localparam logic [7:0] GUARD_ONLY_SELF = 8'h80;
  localparam logic [7:0] GUARD_WITH_OP   = 8'h40;
  localparam logic [7:0] GUARD_WITH_VOUT = 8'h20;
  // Values after reset
  localparam logic [7:0]  GUARD_RESET     = 8'h00;
  localparam logic [7:0]  OPERATION_RESET = 8'h00;
  localparam logic [7:0]  ON_OFF_RESET    = 8'h16;
  localparam logic [15:0] VOUT_RESET      = 16'h0000;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  // Feature byte: error checking, 400 kHz, alert response
  localparam logic [7:0]  FEATURE_VALUE   = 8'hB0;
  // Storage slots
  localparam int MASK_GROUPS  = 7;
  localparam int CFG_SLOTS    = 5;
  localparam int SLOT_GUARD   = 0;
  localparam int SLOT_OP      = 1;
  localparam int SLOT_ON_OFF  = 2;
  localparam int SLOT_VOUT_LO = 3;
  localparam int SLOT_VOUT_HI = 4;
  // Bus silence after store or restore
  localparam int CLOCK_HZ     = 100_000_000;
  localparam int BUSY_TIME_MS = 100;
  localparam int BUSY_CYCLES  = BUSY_TIME_MS * (CLOCK_HZ / 1000);
  // Core sequencer states
  typedef enum logic [1:0] {CORE_IDLE, CORE_STORE, CORE_RESTORE} core_state_t;
endpackage

// ---- hw/pmbus_write_guard_nvm_store.sv ----
// Purpose: Write guard, settings store/reload and feature byte behind the target port
// Assumes: Link side hands over decoded commands on its own clock
// Notes:   Settings memory is not cleared by reset; it stands for the EEPROM
`timescale 1ns/1ps
module pmbus_write_guard_nvm_store #(
  parameter int BUSY_COUNT = pmbus_guard_pkg::BUSY_CYCLES // Silence length in core cycles
) (
  input  wire logic        clock,         // Core clock
  input  wire logic        srst,          // Synchronous reset, high
  input  wire logic        linkClock,     // Target port clock
  input  wire logic        cmdValid,      // Command offered, link domain
  input  wire logic        cmdRead,       // High for read
  input  wire logic [7:0]  cmdCode,       // Command code
  input  wire logic [15:0] cmdData,       // Write data; mask: [7:0] code, [15:8] mask
  output logic             cmdReady,      // Ready for a command
  output logic             respValid,     // Answer pulse, link domain
  output logic             respNack,      // Answer is NACK
  output logic [15:0]      respData,      // Read data
  input  wire logic        nvmWriteFail,  // Memory programming failed, core domain
  input  wire logic [55:0] condFlags,     // Seven status bytes, word first
  output logic [7:0]       guardLevel,    // Write guard register
  output logic [7:0]       operation,     // Operation setting
  output logic [7:0]       onOffConfig,   // On/off setting
  output logic [15:0]      voutCommand,   // Output voltage setting
  output logic             faultIgnore,   // Faults ignored during store
  output logic             stopSwitching, // Switching held off during reload
  output logic             cmlSet,        // Communication fault pulse
  output logic             memSet,        // Memory fault pulse
  output logic             ivdSet,        // Invalid data pulse
  output logic             alertRequest,  // Alert pulse for block events
  output logic             alertActive    // Unmasked condition present
);
  import pmbus_guard_pkg::*;

  // Link side reset and crossing
  logic        linkRstMeta;   // First stage of reset sync
  logic        linkRst;       // Reset in link domain
  logic        reqToggle;     // Flips per handed-over command
  logic        pending;       // Waiting for the core's answer
  logic        holdRead;      // Held command fields
  logic [7:0]  holdCode;
  logic [15:0] holdData;
  logic        ackMeta;       // Answer toggle sync stages
  logic        ackSync;
  logic        ackPrev;
  logic        ackEdge;
  // Core side crossing
  logic        reqMeta;
  logic        reqSync;
  logic        reqPrev;
  logic        reqEdge;
  logic        ackToggle;     // Flips when answer is ready
  logic        coreNack;      // Answer fields, stable across toggle
  logic [15:0] coreData;
  // Core state
  core_state_t state;
  logic [31:0] busyCount;     // Silence counter
  logic [7:0]  alertMask [MASK_GROUPS];
  logic [7:0]  nvmCfg [CFG_SLOTS];
  logic [7:0]  nvmMask [MASK_GROUPS];
  logic [MASK_GROUPS-1:0] gatedCond;

  // Protection check; anything but one valid level leaves writes open
  function automatic logic writeAllowed(input logic [7:0] code, input logic [7:0] lvl);
    case (lvl & GUARD_FIELD)
      GUARD_ONLY_SELF: writeAllowed = (code == CODE_WRITE_GUARD);
      GUARD_WITH_OP:   writeAllowed = (code == CODE_WRITE_GUARD) || (code == CODE_OPERATION);
      GUARD_WITH_VOUT: writeAllowed = (code == CODE_WRITE_GUARD) || (code == CODE_OPERATION)
                                   || (code == CODE_ON_OFF) || (code == CODE_VOUT);
      default:         writeAllowed = 1'b1;
    endcase
  endfunction

  // Status code to mask slot, bit 3 marks a valid code
  function automatic logic [3:0] maskSlot(input logic [7:0] code);
    case (code)
      ST_WORD:  maskSlot = 4'h8;
      ST_VOUT:  maskSlot = 4'h9;
      ST_IOUT:  maskSlot = 4'hA;
      ST_INPUT: maskSlot = 4'hB;
      ST_TEMP:  maskSlot = 4'hC;
      ST_CML:   maskSlot = 4'hD;
      ST_MFR:   maskSlot = 4'hE;
      default:  maskSlot = 4'h0;
    endcase
  endfunction

  // Reset brought into the link domain
  always_ff @(posedge linkClock) begin
    linkRstMeta <= srst;
    linkRst     <= linkRstMeta;
  end

  // Link: take one command, hold it until the answer returns
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      reqToggle <= 1'b0;
      pending   <= 1'b0;
      cmdReady  <= 1'b0;
      holdRead  <= 1'b0;
      holdCode  <= 8'h00;
      holdData  <= 16'h0000;
    end else if (cmdValid && cmdReady && !pending) begin // Never taken unseen by the host
      // Fields are frozen before the toggle is seen in the core
      holdRead  <= cmdRead;
      holdCode  <= cmdCode;
      holdData  <= cmdData;
      reqToggle <= ~reqToggle;
      pending   <= 1'b1;
      cmdReady  <= 1'b0;
    end else if (ackEdge) begin
      pending  <= 1'b0;
      cmdReady <= 1'b1;
    end else begin
      cmdReady <= !pending;
    end
  end

  // Link: answer toggle synchroniser
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
      ackPrev <= 1'b0;
    end else begin
      ackMeta <= ackToggle;
      ackSync <= ackMeta;
      ackPrev <= ackSync;
    end
  end
  assign ackEdge = ackSync ^ ackPrev;

  // Link: present the answer for one link cycle
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      respValid <= 1'b0;
      respNack  <= 1'b0;
      respData  <= 16'h0000;
    end else begin
      respValid <= ackEdge;
      if (ackEdge) begin
        respNack <= coreNack;
        respData <= coreData;
      end
    end
  end

  // Core: request toggle synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
      reqPrev <= 1'b0;
    end else begin
      reqMeta <= reqToggle;
      reqSync <= reqMeta;
      reqPrev <= reqSync;
    end
  end
  assign reqEdge = reqSync ^ reqPrev;

  // Command decode on a new request
  logic       take;
  logic       wrOk;
  logic [3:0] mSlot;
  logic       known;
  logic       guardBad;
  logic       readNack;
  logic       writeNack;
  logic       doWrite;
  logic       storeEnd;
  assign take  = reqEdge && (state == CORE_IDLE);
  assign wrOk  = writeAllowed(holdCode, guardLevel);
  assign mSlot = maskSlot(holdData[7:0]);
  assign known = (holdCode == CODE_OPERATION) || (holdCode == CODE_ON_OFF) || (holdCode == CODE_VOUT)
              || (holdCode == CODE_WRITE_GUARD) || (holdCode == CODE_ALERT_MASK);
  assign guardBad  = (holdCode == CODE_WRITE_GUARD) && !$onehot0(holdData[7:5]);
  assign readNack  = holdRead && !(known || holdCode == CODE_FEATURE);
  // Feature byte is read only; store/restore exempt from the guard
  assign writeNack = !holdRead && !(holdCode == CODE_STORE_ALL || holdCode == CODE_RESTORE_ALL)
                  && (!known || !wrOk || (holdCode == CODE_ALERT_MASK && !mSlot[3]));
  assign doWrite   = take && !holdRead && !writeNack;
  assign storeEnd  = (state == CORE_STORE) && (busyCount == 32'd0);

  // Configuration registers, written by commands or reloaded
  always_ff @(posedge clock) begin
    if (srst) begin
      guardLevel  <= GUARD_RESET;
      operation   <= OPERATION_RESET;
      onOffConfig <= ON_OFF_RESET;
      voutCommand <= VOUT_RESET;
      for (int i = 0; i < MASK_GROUPS; i++) alertMask[i] <= MASK_RESET;
    end else if (doWrite && holdCode == CODE_RESTORE_ALL) begin
      // Guard is never protected against itself, so it always reloads
      guardLevel <= nvmCfg[SLOT_GUARD] & GUARD_FIELD;
      if (writeAllowed(CODE_OPERATION, guardLevel)) operation <= nvmCfg[SLOT_OP];
      if (writeAllowed(CODE_ON_OFF, guardLevel)) onOffConfig <= nvmCfg[SLOT_ON_OFF];
      if (writeAllowed(CODE_VOUT, guardLevel)) voutCommand <= {nvmCfg[SLOT_VOUT_HI], nvmCfg[SLOT_VOUT_LO]};
      if (writeAllowed(CODE_ALERT_MASK, guardLevel)) begin
        for (int i = 0; i < MASK_GROUPS; i++) alertMask[i] <= nvmMask[i];
      end
    end else if (doWrite) begin
      case (holdCode)
        // Invalid combinations are kept; decode then protects nothing
        CODE_WRITE_GUARD: guardLevel  <= holdData[7:0] & GUARD_FIELD;
        CODE_OPERATION:   operation   <= holdData[7:0];
        CODE_ON_OFF:      onOffConfig <= holdData[7:0];
        CODE_VOUT:        voutCommand <= holdData;
        CODE_ALERT_MASK:  alertMask[mSlot[2:0]] <= holdData[15:8];
        default: ;
      endcase
    end
  end

  // Settings memory; holds its content across reset
  always_ff @(posedge clock) begin
    if (storeEnd && !nvmWriteFail) begin
      nvmCfg[SLOT_GUARD]   <= guardLevel;
      nvmCfg[SLOT_OP]      <= operation;
      nvmCfg[SLOT_ON_OFF]  <= onOffConfig;
      nvmCfg[SLOT_VOUT_LO] <= voutCommand[7:0];
      nvmCfg[SLOT_VOUT_HI] <= voutCommand[15:8];
      for (int i = 0; i < MASK_GROUPS; i++) nvmMask[i] <= alertMask[i];
    end
  end

  // Sequencer: immediate answers, or silence then answer
  always_ff @(posedge clock) begin
    if (srst) begin
      state         <= CORE_IDLE;
      busyCount     <= 32'd0;
      ackToggle     <= 1'b0;
      coreNack      <= 1'b0;
      coreData      <= 16'h0000;
      faultIgnore   <= 1'b0;
      stopSwitching <= 1'b0;
    end else begin
      case (state)
        CORE_IDLE: begin
          if (take && !holdRead && (holdCode == CODE_STORE_ALL || holdCode == CODE_RESTORE_ALL)) begin
            // Answer withheld so the bus stays silent for the whole count
            busyCount <= 32'(BUSY_COUNT - 1);
            if (holdCode == CODE_STORE_ALL) begin
              state       <= CORE_STORE;
              faultIgnore <= 1'b1;
            end else begin
              state         <= CORE_RESTORE;
              stopSwitching <= 1'b1;
            end
          end else if (take) begin
            ackToggle <= ~ackToggle;
            coreNack  <= readNack || writeNack;
            case (holdCode)
              CODE_OPERATION:   coreData <= {8'h00, operation};
              CODE_ON_OFF:      coreData <= {8'h00, onOffConfig};
              CODE_WRITE_GUARD: coreData <= {8'h00, guardLevel};
              CODE_FEATURE:     coreData <= {8'h00, FEATURE_VALUE};
              CODE_VOUT:        coreData <= voutCommand;
              // Unknown status code reads back zero
              CODE_ALERT_MASK:  coreData <= mSlot[3] ? {8'h00, alertMask[mSlot[2:0]]} : 16'h0000;
              default:          coreData <= 16'h0000;
            endcase
          end
        end
        CORE_STORE, CORE_RESTORE: begin
          if (busyCount == 32'd0) begin
            state         <= CORE_IDLE;
            faultIgnore   <= 1'b0;
            stopSwitching <= 1'b0;
            ackToggle     <= ~ackToggle;
            coreNack      <= storeEnd && nvmWriteFail;
            coreData      <= 16'h0000;
          end else begin
            busyCount <= busyCount - 32'd1;
          end
        end
        default: state <= CORE_IDLE;
      endcase
    end
  end

  // Status event pulses toward the status and alert logic
  always_ff @(posedge clock) begin
    if (srst) begin
      cmlSet       <= 1'b0;
      memSet       <= 1'b0;
      ivdSet       <= 1'b0;
      alertRequest <= 1'b0;
    end else begin
      cmlSet <= (take && (readNack || writeNack || (doWrite && guardBad)))
             || (storeEnd && nvmWriteFail);
      memSet <= storeEnd && nvmWriteFail;
      ivdSet <= take && !holdRead && holdCode == CODE_ALERT_MASK && wrOk && !mSlot[3];
      alertRequest <= (take && (readNack || writeNack || (doWrite && guardBad)))
                   || (storeEnd && nvmWriteFail);
    end
  end

  // Mask each status byte bit for bit against its mask
  genvar g;
  generate
    for (g = 0; g < MASK_GROUPS; g++) begin : gate
      assign gatedCond[g] = |(condFlags[g*8 +: 8] & ~alertMask[g]);
    end
  endgenerate

  // Alert level; held off while a store ignores faults
  always_ff @(posedge clock) begin
    if (srst) alertActive <= 1'b0;
    else      alertActive <= (|gatedCond) && !faultIgnore;
  end
endmodule

// ---- verif/pmbus_guard_monitor.sv ----
// Purpose: Concurrent checks on the guard and store block ports
// Assumes: Short silence count handed on by the bind
// Notes:   Two domains, so each property names its own clock
`timescale 1ns/1ps
module pmbus_guard_monitor #(
  parameter int BUSY_COUNT = 20 // Silence length
) (
  input wire logic        clock,         // Core clock
  input wire logic        srst,          // Reset
  input wire logic        linkClock,     // Link clock
  input wire logic        cmdReady,      // Ready
  input wire logic        respValid,     // Answer pulse
  input wire logic [7:0]  guardLevel,    // Guard
  input wire logic [7:0]  operation,     // Operation
  input wire logic [7:0]  onOffConfig,   // On/off
  input wire logic [15:0] voutCommand,   // Vout
  input wire logic        faultIgnore,   // Store silence
  input wire logic        stopSwitching, // Reload silence
  input wire logic        cmlSet,        // Cml pulse
  input wire logic        memSet,        // Mem pulse
  input wire logic        ivdSet,        // Ivd pulse
  input wire logic        alertRequest,  // Alert pulse
  input wire logic        alertActive    // Alert level
);
  logic [31:0] busyCnt; // Cycles of the current store silence
  // Counter, since the silence is far too long for a repetition
  always_ff @(posedge clock) begin
    if (srst || !faultIgnore) begin
      busyCnt <= 32'h0;
    end else begin
      busyCnt <= busyCnt + 32'h1;
    end
  end
  // Answer closes: pulse gone and target ready again
  sequence s_close;
    !respValid && cmdReady;
  endsequence
  a_mem_with_cml:
  assert property (@(posedge clock) disable iff (srst) memSet |-> cmlSet && alertRequest)
    else $error("memory fault without cml and alert");
  a_cml_alert:
  assert property (@(posedge clock) disable iff (srst) cmlSet |-> alertRequest)
    else $error("cml without alert");
  a_ivd_cml:
  assert property (@(posedge clock) disable iff (srst) ivdSet |-> cmlSet)
    else $error("invalid data without cml");
  a_store_silence:
  assert property (@(posedge clock) disable iff (srst)
    $fell(faultIgnore) |-> busyCnt >= 32'(BUSY_COUNT - 1) && busyCnt <= 32'(BUSY_COUNT + 4))
    else $error("store silence length wrong");
  a_reload_hold:
  assert property (@(posedge clock) disable iff (srst) $rose(stopSwitching) |-> stopSwitching[*8])
    else $error("switching released too early");
  a_ignore_quiet:
  assert property (@(posedge clock) disable iff (srst) faultIgnore && $past(faultIgnore) |-> !alertActive)
    else $error("alert during store");
  a_self_only:
  assert property (@(posedge clock) disable iff (srst)
    guardLevel == 8'h80 && $past(guardLevel) == 8'h80 |-> $stable(operation))
    else $error("operation changed under full guard");
  a_op_only:
  assert property (@(posedge clock) disable iff (srst)
    guardLevel inside {8'h40, 8'h80} && $past(guardLevel) inside {8'h40, 8'h80}
    |-> $stable(onOffConfig) && $stable(voutCommand))
    else $error("setting changed under guard");
  a_busy_exclusive:
  assert property (@(posedge clock) disable iff (srst) !(faultIgnore && stopSwitching))
    else $error("store and reload overlap");
  a_answer_close:
  assert property (@(posedge linkClock) disable iff (srst) respValid |-> cmdReady ##1 s_close)
    else $error("answer pulse malformed");
endmodule
bind pmbus_write_guard_nvm_store pmbus_guard_monitor #(.BUSY_COUNT(BUSY_COUNT)) u_pmbus_guard_monitor (
  .clock(clock), .srst(srst), .linkClock(linkClock), .cmdReady(cmdReady), .respValid(respValid),
  .guardLevel(guardLevel), .operation(operation), .onOffConfig(onOffConfig), .voutCommand(voutCommand),
  .faultIgnore(faultIgnore), .stopSwitching(stopSwitching), .cmlSet(cmlSet), .memSet(memSet),
  .ivdSet(ivdSet), .alertRequest(alertRequest), .alertActive(alertActive));

// ---- verif/host_ctrl_model.sv ----
// Purpose: Host controller issuing one command at a time
// Assumes: Signals change at the falling link edge
// Notes:   Released lines show inverted data
`timescale 1ns/1ps
module host_ctrl_model (
  input  wire logic   linkClock,  // Link clock
  input  wire logic   cmdReady,   // Target ready
  input  wire logic   respValid,  // Answer pulse
  output logic        cmdValid,   // Offer
  output logic        cmdRead,    // Read
  output logic [7:0]  cmdCode,    // Code
  output logic [15:0] cmdData,    // Data
  output logic        hostTimeout // Wait ran out
);
  initial begin
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
    hostTimeout = 1'b0;
  end
  // Offer held until an edge finds the target ready
  task automatic issue(input logic rd, input logic [7:0] code, input logic [15:0] data);
    int n;
    n = 0;
    @(negedge linkClock);
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdCode = code;
    cmdData = data;
    do begin
      @(posedge linkClock);
      n++;
    end while (cmdReady !== 1'b1 && n < 400);
    @(negedge linkClock);
    cmdValid = 1'b0;
    cmdCode = ~cmdCode; // Stale values would hide a late sample
    cmdData = ~cmdData;
    // Nothing expected during the silence, just a bounded wait
    while (respValid !== 1'b1 && n < 800) begin
      @(posedge linkClock);
      n++;
    end
    if (n >= 800) begin
      hostTimeout = 1'b1;
    end
  endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the write guard and settings store
// Assumes: Silence shortened to 20 core cycles
// Notes:   Answers checked from a queue by a watcher
`timescale 1ns/1ps
module tb;
  import pmbus_guard_pkg::*;
  typedef struct packed {logic nack; logic [15:0] data; logic [15:0] care;} expect_t;
  logic        clock, srst, linkClock, cmdValid, cmdRead, cmdReady, respValid, respNack; // Link side
  logic        hostTimeout, nvmWriteFail, faultIgnore, stopSwitching, alertActive; // Core side
  logic [7:0]  cmdCode, guardLevel, operation, onOffConfig; // Bytes
  logic [15:0] cmdData, respData, voutCommand, v; // Words
  logic [55:0] condFlags; // Status conditions
  logic        cmlSet, memSet, ivdSet, alertRequest; // Event pulses
  int          nCml = 0, nMem = 0, nIvd = 0, nAlert = 0, expCml = 0; // Pulse tallies
  logic [15:0] sh [3];    // Expected op, on/off, vout
  logic [7:0]  lv [4] = '{8'h00, 8'h20, 8'h40, 8'h80};
  logic [7:0]  codes [4] = '{CODE_OPERATION, CODE_ON_OFF, CODE_VOUT, CODE_ALERT_MASK};
  expect_t     expQ [$];  // Pending answers
  int          n_mismatch = 0;
  int          cmp_count = 0;
  integer      seed = 32'h923b8dd4;
  initial clock = 1'b0;
  initial linkClock = 1'b0;
  always #5 clock = ~clock;
  always #62.5 linkClock = ~linkClock;
  pmbus_write_guard_nvm_store #(.BUSY_COUNT(20)) u_pmbus_write_guard_nvm_store (
    .clock(clock), .srst(srst), .linkClock(linkClock), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdData(cmdData), .cmdReady(cmdReady), .respValid(respValid),
    .respNack(respNack), .respData(respData), .nvmWriteFail(nvmWriteFail), .condFlags(condFlags),
    .guardLevel(guardLevel), .operation(operation), .onOffConfig(onOffConfig),
    .voutCommand(voutCommand), .faultIgnore(faultIgnore), .stopSwitching(stopSwitching),
    .cmlSet(cmlSet), .memSet(memSet), .ivdSet(ivdSet), .alertRequest(alertRequest), .alertActive(alertActive));
  host_ctrl_model u_host_ctrl_model (
    .linkClock(linkClock), .cmdReady(cmdReady), .respValid(respValid), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdData(cmdData), .hostTimeout(hostTimeout));
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_resp(input expect_t e);
    cmp_count++;
    if (respNack !== e.nack || (respData & e.care) !== e.data) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h %h exp %h %h", $time, respNack, respData, e.nack, e.data);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Note the expected answer, then let the host send the command
  task automatic cmd(input logic rd, input logic [7:0] code, input logic [15:0] data,
                     input logic nack, input logic [15:0] exp, input logic [15:0] care);
    expQ.push_back('{nack, exp & care, care});
    if (nack) expCml++;
    u_host_ctrl_model.issue(rd, code, data);
    if (hostTimeout) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no answer code %h data %h", $time, code, data);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic nack);
    cmd(1'b0, code, data, nack, 16'h0000, 16'h0000);
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] data, input logic [15:0] exp, input logic [15:0] care);
    cmd(1'b1, code, data, 1'b0, exp, care);
  endtask
  // Expected refusal for a write under a guard level
  function automatic logic refused(input logic [7:0] g, input logic [7:0] code);
    if (code == CODE_WRITE_GUARD) return 1'b0;
    case (g)
      GUARD_ONLY_SELF: return 1'b1;
      GUARD_WITH_OP:   return code != CODE_OPERATION;
      GUARD_WITH_VOUT: return !(code inside {CODE_OPERATION, CODE_ON_OFF, CODE_VOUT});
      default:         return 1'b0;
    endcase
  endfunction
  // Watcher: each answer takes the oldest note
  always @(posedge linkClock) begin
    if (respValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_mismatch++;
        $display("MISMATCH t=%0t got %h exp none %h", $time, respData, 16'h0000);
      end else begin
        chk_resp(expQ.pop_front());
      end
    end
  end
  // Event pulse tallies, compared at the end
  always @(posedge clock) begin
    if (cmlSet === 1'b1) nCml++;
    if (memSet === 1'b1) nMem++;
    if (ivdSet === 1'b1) nIvd++;
    if (alertRequest === 1'b1) nAlert++;
  end
  initial begin
    srst = 1'b1;
    nvmWriteFail = 1'b0;
    condFlags = '0;
    sh = '{16'h0000, 16'h0016, 16'h0000};
    repeat (16) @(negedge clock);
    repeat (3) @(negedge linkClock);
    @(negedge clock) srst = 1'b0;
    for (int n = 0; n < 50 && cmdReady !== 1'b1; n++) @(negedge linkClock);
    if (cmdReady !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t ready never rose got %h exp %h", $time, cmdReady, 1'b1);
      results();
    end
    rd(CODE_FEATURE, 16'h0000, {8'h00, FEATURE_VALUE}, 16'h00FF);
    wr(CODE_FEATURE, 16'h00FF, 1'b1);
    cmd(1'b1, 8'h55, 16'h0000, 1'b1, 16'h0000, 16'h0000);
    $display("test feature done");
    wr(CODE_ALERT_MASK, {8'h40, ST_TEMP}, 1'b0);
    rd(CODE_ALERT_MASK, {8'h00, ST_TEMP}, 16'h0040, 16'h00FF);
    wr(CODE_ALERT_MASK, {8'h01, 8'h55}, 1'b1);
    rd(CODE_ALERT_MASK, {8'h00, 8'h55}, 16'h0000, 16'h00FF);
    @(negedge clock) condFlags[39:32] = 8'h40;
    repeat (4) @(negedge clock);
    chk_val({15'h0, alertActive}, 16'h0000);
    condFlags[39:32] = 8'h20;
    repeat (4) @(negedge clock);
    chk_val({15'h0, alertActive}, 16'h0001);
    $display("test mask done");
    foreach (lv[i]) begin
      wr(CODE_WRITE_GUARD, {8'h00, lv[i]}, 1'b0);
      for (int k = 0; k < 4; k++) begin
        v = 16'($random(seed)) & 16'h07FF;
        if (k == 3) v = {v[15:8], ST_MFR};
        wr(codes[k], v, refused(lv[i], codes[k]));
        if (k < 3 && !refused(lv[i], codes[k])) sh[k] = v;
      end
      rd(CODE_OPERATION, 16'h0000, sh[0], 16'h00FF);
      chk_val(voutCommand, sh[2]);
      chk_val({8'h00, onOffConfig & 8'h1F}, sh[1] & 16'h001F);
    end
    wr(CODE_WRITE_GUARD, 16'h00E0, 1'b0);
    expCml++; // Invalid guard is acknowledged yet still flags cml
    rd(CODE_WRITE_GUARD, 16'h0000, 16'h00E0, 16'h00FF);
    wr(CODE_OPERATION, 16'h005A, 1'b0);
    chk_val({8'h00, operation}, 16'h005A);
    $display("test guard done");
    wr(CODE_WRITE_GUARD, 16'h0000, 1'b0);
    wr(CODE_OPERATION, 16'h00A1, 1'b0);
    wr(CODE_VOUT, 16'h0123, 1'b0);
    wr(CODE_STORE_ALL, 16'h0000, 1'b0);
    @(negedge clock) condFlags = '0;
    wr(CODE_OPERATION, 16'h0043, 1'b0);
    wr(CODE_VOUT, 16'h0456, 1'b0);
    wr(CODE_WRITE_GUARD, 16'h0040, 1'b0);
    wr(CODE_RESTORE_ALL, 16'h0000, 1'b0);
    chk_val({8'h00, guardLevel}, 16'h0000);
    chk_val({8'h00, operation}, 16'h00A1);
    chk_val(voutCommand, 16'h0456);
    wr(CODE_OPERATION, 16'h0021, 1'b0);
    wr(CODE_RESTORE_ALL, 16'h0000, 1'b0);
    chk_val(voutCommand, 16'h0123);
    wr(CODE_OPERATION, 16'h0067, 1'b0);
    @(negedge clock) nvmWriteFail = 1'b1;
    wr(CODE_STORE_ALL, 16'h0000, 1'b1);
    @(negedge clock) nvmWriteFail = 1'b0;
    wr(CODE_RESTORE_ALL, 16'h0000, 1'b0);
    chk_val({8'h00, operation}, 16'h00A1);
    $display("test store done");
    chk_val(16'(nCml), 16'(expCml));
    chk_val(16'(nAlert), 16'(expCml));
    chk_val(16'(nMem), 16'h0001);
    chk_val(16'(nIvd), 16'h0001);
    results();
  end
endmodule
